// [common/dpa_defs.vh]
// Constants for the dual-port slave address selection block
`ifndef DPA_DEFS_VH
`define DPA_DEFS_VH

// Upper nibble of both primary interface addresses
`define DPA_PRI_ADDR_HI 4'h4
// Fixed 7-bit addresses of the secondary interface
`define DPA_SEC_ADDR_P1 7'h38
`define DPA_SEC_ADDR_P2 7'h3F
// Top bit of the three-bit strap code that tells the two ports apart
`define DPA_CODE_P1_TOP 1'b0
`define DPA_CODE_P2_TOP 1'b1
// Band edges of the divider ratio in per-mille of full scale
`define DPA_BAND1_PERMILLE 100
`define DPA_BAND2_PERMILLE 390
`define DPA_BAND3_PERMILLE 790
// Per-mille scale
`define DPA_PERMILLE_FULL 1000
// Default converter result width
`define DPA_ADC_WIDTH 10
// Number of events that may raise an interface interrupt
`define DPA_EVT_WIDTH 8

`endif

// [core/dpa_i2c_addr.v]
// Two I2C slave interfaces, each answering on two port addresses
`timescale 1ns/1ps
`include "dpa_defs.vh"

module dpa_i2c_addr #(
	parameter ADC_W = `DPA_ADC_WIDTH,
	parameter EVT_W = `DPA_EVT_WIDTH
) (
	input wire ref_clk,
	input wire nrst,
	input wire boot_done,
	input wire strap_adc_valid,
	input wire [ADC_W-1:0] strap_adc_code,
	input wire [27:0] addr_ovr_mask,
	input wire [27:0] addr_ovr_value,
	input wire [1:0] scl_in,
	output wire [1:0] scl_out,
	output wire [1:0] scl_oe,
	input wire [1:0] sda_in,
	output wire [1:0] sda_out,
	output wire [1:0] sda_oe,
	output wire [1:0] hi_port,
	output wire [15:0] hi_subaddr,
	output wire [1:0] hi_wr_stb,
	output wire [15:0] hi_wdata,
	output wire [1:0] hi_rd_stb,
	input wire [1:0] hi_rdy,
	input wire [15:0] hi_rd_data,
	input wire [EVT_W-1:0] evt_in,
	input wire [2*EVT_W-1:0] irq_mask,
	output wire [1:0] irq_out,
	output wire addr_ready
);

	// Byte engine states
	localparam [2:0] S_IDLE = 3'h0;
	localparam [2:0] S_ADDR = 3'h1;
	localparam [2:0] S_ACKA = 3'h2;
	localparam [2:0] S_WR = 3'h3;
	localparam [2:0] S_ACKW = 3'h4;
	localparam [2:0] S_RDWAIT = 3'h5;
	localparam [2:0] S_RD = 3'h6;
	localparam [2:0] S_RACK = 3'h7;
	wire [2:0] code_p1, code_p2;
	wire strap_done;
	reg ready_ff;

	dpa_strap_decode #(
		.ADC_W(ADC_W)
	) u_strap (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.adc_valid(strap_adc_valid),
		.adc_code(strap_adc_code),
		.first_port_strap_code_ff(code_p1),
		.second_port_strap_code_ff(code_p2),
		.strap_done_ff(strap_done)
	);

	// Interfaces open only once both the strap and the boot flow are done
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ready_ff <= 1'b0;
		end else begin
			ready_ff <= boot_done & strap_done;
		end
	end

	assign addr_ready = ready_ff;
	// Open-drain pins only ever pull low
	assign scl_out = 2'b00;
	assign sda_out = 2'b00;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_if
			reg [2:0] st_ff, nxt_st;
			reg [3:0] bit_ff, nxt_bit;
			reg [7:0] sh_ff, nxt_sh, sub_ff, nxt_sub;
			reg [7:0] wdata_ff, nxt_wdata;
			reg port_ff, rw_ff, first_ff, wr_stb_ff, rd_stb_ff;
			reg sda_oe_ff, scl_oe_ff, scl_d_ff, sda_d_ff, irq_ff;
			reg nxt_port, nxt_rw, nxt_first, nxt_wr_stb, nxt_rd_stb;
			reg nxt_sda_oe, nxt_scl_oe;
			wire [6:0] dflt_p1, dflt_p2, msk_p1, msk_p2;
			wire [6:0] eff_p1, eff_p2;
			wire scl_rise, scl_fall, start_c, stop_c;
			wire [7:0] rd_byte;
			// Strapped addresses on the primary, fixed ones on the secondary
			if (gi == 0) begin : g_pri
				assign dflt_p1 = {`DPA_PRI_ADDR_HI, code_p1};
				assign dflt_p2 = {`DPA_PRI_ADDR_HI, code_p2};
			end else begin : g_sec
				assign dflt_p1 = `DPA_SEC_ADDR_P1;
				assign dflt_p2 = `DPA_SEC_ADDR_P2;
			end
			// Masked bits take the firmware value instead of the default
			assign msk_p1 = addr_ovr_mask[gi*14 +: 7];
			assign msk_p2 = addr_ovr_mask[gi*14+7 +: 7];
			assign eff_p1 = (dflt_p1 & ~msk_p1) |
				(addr_ovr_value[gi*14 +: 7] & msk_p1);
			assign eff_p2 = (dflt_p2 & ~msk_p2) |
				(addr_ovr_value[gi*14+7 +: 7] & msk_p2);
			// Bus events; edges are seen per system clock, fine at 400 kHz
			assign scl_rise = scl_in[gi] & ~scl_d_ff;
			assign scl_fall = ~scl_in[gi] & scl_d_ff;
			assign start_c = scl_in[gi] & scl_d_ff & sda_d_ff & ~sda_in[gi];
			assign stop_c = scl_in[gi] & scl_d_ff & ~sda_d_ff & sda_in[gi];
			assign rd_byte = hi_rd_data[gi*8 +: 8];
			// Byte engine next state
			always @* begin
				nxt_st = st_ff;
				nxt_bit = bit_ff;
				nxt_sh = sh_ff;
				nxt_port = port_ff;
				nxt_rw = rw_ff;
				nxt_first = first_ff;
				nxt_sub = sub_ff;
				nxt_wdata = wdata_ff;
				nxt_wr_stb = 1'b0;
				nxt_rd_stb = 1'b0;
				nxt_sda_oe = sda_oe_ff;
				nxt_scl_oe = scl_oe_ff;
				if (!ready_ff) begin
					nxt_st = S_IDLE;
					nxt_sda_oe = 1'b0;
					nxt_scl_oe = 1'b0;
				end else if (start_c) begin
					// Repeated start keeps the sub-address for SMBus reads
					nxt_st = S_ADDR;
					nxt_bit = 4'h0;
					nxt_sda_oe = 1'b0;
					nxt_scl_oe = 1'b0;
				end else if (stop_c) begin
					nxt_st = S_IDLE;
					nxt_sda_oe = 1'b0;
					nxt_scl_oe = 1'b0;
				end else begin
					case (st_ff)
					S_ADDR: begin
						if (scl_rise) begin
							nxt_sh = {sh_ff[6:0], sda_in[gi]};
							nxt_bit = bit_ff + 4'h1;
						end else if (scl_fall && bit_ff == 4'h8) begin
							nxt_rw = sh_ff[0];
							nxt_port = (sh_ff[7:1] == eff_p2);
							if (sh_ff[7:1] == eff_p1 ||
								sh_ff[7:1] == eff_p2) begin
								nxt_sda_oe = 1'b1;
								nxt_st = S_ACKA;
							end else begin
								nxt_st = S_IDLE;
							end
						end
					end
					S_ACKA: begin
						if (scl_fall) begin
							nxt_bit = 4'h0;
							nxt_sda_oe = 1'b0;
							if (rw_ff) begin
								nxt_rd_stb = 1'b1;
								nxt_scl_oe = 1'b1;
								nxt_st = S_RDWAIT;
							end else begin
								nxt_first = 1'b1;
								nxt_st = S_WR;
							end
						end
					end
					S_WR: begin
						if (scl_rise) begin
							nxt_sh = {sh_ff[6:0], sda_in[gi]};
							nxt_bit = bit_ff + 4'h1;
						end else if (scl_fall && bit_ff == 4'h8) begin
							nxt_sda_oe = 1'b1;
							nxt_first = 1'b0;
							nxt_st = S_ACKW;
							if (first_ff) begin
								nxt_sub = sh_ff;
							end else begin
								nxt_wdata = sh_ff;
								nxt_wr_stb = 1'b1;
								nxt_scl_oe = 1'b1;
							end
						end
					end
					S_ACKW: begin
						// Hold the clock until the command side takes the byte
						if (scl_oe_ff && hi_rdy[gi]) begin
							nxt_scl_oe = 1'b0;
						end else if (!scl_oe_ff && scl_fall) begin
							nxt_sda_oe = 1'b0;
							nxt_bit = 4'h0;
							nxt_st = S_WR;
						end
					end
					S_RDWAIT: begin
						if (hi_rdy[gi]) begin
							nxt_sh = rd_byte;
							nxt_sda_oe = ~rd_byte[7];
							nxt_scl_oe = 1'b0;
							nxt_bit = 4'h0;
							nxt_st = S_RD;
						end
					end
					S_RD: begin
						if (scl_fall) begin
							nxt_bit = bit_ff + 4'h1;
							if (bit_ff == 4'h7) begin
								nxt_sda_oe = 1'b0;
								nxt_st = S_RACK;
							end else begin
								nxt_sh = {sh_ff[6:0], 1'b0};
								nxt_sda_oe = ~sh_ff[6];
							end
						end
					end
					S_RACK: begin
						// A not-acknowledge ends the read; wait for stop
						if (scl_rise && sda_in[gi]) begin
							nxt_st = S_IDLE;
						end else if (scl_fall) begin
							nxt_rd_stb = 1'b1;
							nxt_scl_oe = 1'b1;
							nxt_st = S_RDWAIT;
						end
					end
					default: begin
						nxt_st = S_IDLE;
						nxt_sda_oe = 1'b0;
						nxt_scl_oe = 1'b0;
					end
					endcase
				end
			end

			// Byte engine registers
			always @(posedge ref_clk or negedge nrst) begin
				if (!nrst) begin
					st_ff <= S_IDLE;
					bit_ff <= 4'h0;
					sh_ff <= 8'h00;
					port_ff <= 1'b0;
					rw_ff <= 1'b0;
					first_ff <= 1'b0;
					sub_ff <= 8'h00;
					wdata_ff <= 8'h00;
					wr_stb_ff <= 1'b0;
					rd_stb_ff <= 1'b0;
					sda_oe_ff <= 1'b0;
					scl_oe_ff <= 1'b0;
					scl_d_ff <= 1'b1;
					sda_d_ff <= 1'b1;
					irq_ff <= 1'b0;
				end else begin
					st_ff <= nxt_st;
					bit_ff <= nxt_bit;
					sh_ff <= nxt_sh;
					port_ff <= nxt_port;
					rw_ff <= nxt_rw;
					first_ff <= nxt_first;
					sub_ff <= nxt_sub;
					wdata_ff <= nxt_wdata;
					wr_stb_ff <= nxt_wr_stb;
					rd_stb_ff <= nxt_rd_stb;
					sda_oe_ff <= nxt_sda_oe;
					scl_oe_ff <= nxt_scl_oe;
					scl_d_ff <= scl_in[gi];
					sda_d_ff <= sda_in[gi];
					irq_ff <= |(evt_in & irq_mask[gi*EVT_W +: EVT_W]);
				end
			end

			// Per-interface outputs
			assign sda_oe[gi] = sda_oe_ff;
			assign scl_oe[gi] = scl_oe_ff;
			assign hi_port[gi] = port_ff;
			assign hi_subaddr[gi*8 +: 8] = sub_ff;
			assign hi_wdata[gi*8 +: 8] = wdata_ff;
			assign hi_wr_stb[gi] = wr_stb_ff;
			assign hi_rd_stb[gi] = rd_stb_ff;
			assign irq_out[gi] = irq_ff;
		end
	endgenerate

endmodule // dpa_i2c_addr

// [core/dpa_strap_decode.v]
// Strap band quantiser giving the per-port address codes
`timescale 1ns/1ps
`include "dpa_defs.vh"

module dpa_strap_decode #(
	parameter ADC_W = `DPA_ADC_WIDTH
) (
	input wire ref_clk,
	input wire nrst,
	input wire adc_valid,
	input wire [ADC_W-1:0] adc_code,
	output reg [2:0] first_port_strap_code_ff,
	output reg [2:0] second_port_strap_code_ff,
	output reg strap_done_ff
);

	// Full-scale code and the three band edges scaled to it
	localparam [31:0] FULL = (32'h1 << ADC_W) - 32'h1;
	localparam [31:0] THR1 = `DPA_BAND1_PERMILLE * FULL / `DPA_PERMILLE_FULL;
	localparam [31:0] THR2 = `DPA_BAND2_PERMILLE * FULL / `DPA_PERMILLE_FULL;
	localparam [31:0] THR3 = `DPA_BAND3_PERMILLE * FULL / `DPA_PERMILLE_FULL;

	wire [31:0] code_ext;
	reg [1:0] band;
	reg [2:0] nxt_first_port_strap_code;
	reg [2:0] nxt_second_port_strap_code;
	reg nxt_strap_done;

	assign code_ext = {{(32-ADC_W){1'b0}}, adc_code};

	// Edges sit in the gaps between bands, so a 1% divider lands safely
	always @* begin
		if (code_ext < THR1) begin
			band = 2'h0;
		end else if (code_ext < THR2) begin
			band = 2'h1;
		end else if (code_ext < THR3) begin
			band = 2'h2;
		end else begin
			band = 2'h3;
		end
	end

	// Only the first result after reset is kept; later samples are ignored
	always @* begin
		nxt_first_port_strap_code = first_port_strap_code_ff;
		nxt_second_port_strap_code = second_port_strap_code_ff;
		nxt_strap_done = strap_done_ff;
		if (adc_valid && !strap_done_ff) begin
			nxt_first_port_strap_code = {`DPA_CODE_P1_TOP, band};
			nxt_second_port_strap_code = {`DPA_CODE_P2_TOP, band};
			nxt_strap_done = 1'b1;
		end
	end

	// Strap state
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			first_port_strap_code_ff <= {`DPA_CODE_P1_TOP, 2'h0};
			second_port_strap_code_ff <= {`DPA_CODE_P2_TOP, 2'h0};
			strap_done_ff <= 1'b0;
		end else begin
			first_port_strap_code_ff <= nxt_first_port_strap_code;
			second_port_strap_code_ff <= nxt_second_port_strap_code;
			strap_done_ff <= nxt_strap_done;
		end
	end

endmodule // dpa_strap_decode

// [test/dpa_i2c_addr_bench.sv]
// Self-checking bench for the slave address block
`timescale 1ns/1ps
module dpa_i2c_addr_bench;
	reg ref_clk, nrst, boot_done, strap_adc_valid, a;
	reg [9:0] strap_adc_code;
	reg [27:0] addr_ovr_mask, addr_ovr_value;
	reg [3:0] stall = 4'h0;
	wire [1:0] hi_rdy;
	reg [15:0] hi_rd_data, irq_mask;
	reg [7:0] evt_in, wseen, b;
	wire [1:0] scl_in, scl_out, scl_oe, sda_in, sda_out, sda_oe, m_scl, m_sda;
	wire [1:0] hi_port, hi_wr_stb, hi_rd_stb, irq_out;
	wire [15:0] hi_subaddr, hi_wdata;
	wire addr_ready;
	integer err_count = 0, comparisons = 0, cyc = 0, held = 0;
	// Pulled-up open-drain wires: low when anyone pulls
	assign scl_in = ~(scl_oe | m_scl);
	assign sda_in = ~(sda_oe | m_sda);
	dpa_i2c_addr i_dpa_i2c_addr (.ref_clk, .nrst, .boot_done, .strap_adc_valid,
		.strap_adc_code, .addr_ovr_mask, .addr_ovr_value, .scl_in, .scl_out,
		.scl_oe, .sda_in, .sda_out, .sda_oe, .hi_port, .hi_subaddr, .hi_wr_stb,
		.hi_wdata, .hi_rd_stb, .hi_rdy, .hi_rd_data, .evt_in, .irq_mask,
		.irq_out, .addr_ready);
	dpa_mst i_dpa_mst (.ref_clk, .scl(scl_in), .sda(sda_in), .scl_low(m_scl),
		.sda_low(m_sda));
	always #2 ref_clk = ~ref_clk;
	// Primary command side answers eight cycles after a strobe, so that slave stretches; the secondary is always ready
	assign hi_rdy = {1'h1, stall == 4'h0};
	always @(negedge ref_clk) begin
		if (hi_wr_stb[0] | hi_rd_stb[0])
			stall <= 4'h8;
		else if (stall != 4'h0)
			stall <= stall - 4'h1;
	end
	// Capture handed-over write bytes; cut a hung run short
	always @(posedge ref_clk) begin
		if (hi_wr_stb[0])
			wseen <= hi_wdata[7:0];
		// Cycles the primary interface held its clock low
		if (scl_oe[0])
			held <= held + 1;
		cyc = cyc + 1;
		if (cyc == 20000) begin
			err_count = err_count + 1;
			print_verdict;
		end
	end
	task chk(input [8*8:1] nm, input [15:0] s, input [15:0] e);
		begin
			comparisons = comparisons + 1;
			if (s !== e) begin
				err_count = err_count + 1;
				$display("mismatch %0s expected %h seen %h", nm, e, s);
			end
		end
	endtask
	task print_verdict;
		begin
			if (err_count == 0 && comparisons > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	// Address-only transfer; a holds the acknowledge
	task probe(input integer i, input [6:0] ad);
		begin
			i_dpa_mst.cnd(i, 1'h1);
			i_dpa_mst.wb({ad, 1'h0}, a);
			i_dpa_mst.cnd(i, 1'h0);
		end
	endtask
	task reset(input [9:0] c);
		begin
			@(negedge ref_clk);
			nrst = 1'h0;
			boot_done = 1'h0;
			strap_adc_code = c;
			repeat (5) @(negedge ref_clk);
			nrst = 1'h1;
			repeat (3) @(negedge ref_clk);
		end
	endtask
	// Every strap band at its edge code, before and after boot
	task t_strap;
		integer k;
		begin
			for (k = 0; k < 4; k = k + 1) begin
				reset(k == 0 ? 10'h065 : k == 1 ? 10'h18D :
					k == 2 ? 10'h327 : 10'h328);
				probe(0, {4'h4, 1'h0, k[1:0]});
				chk("early", a, 16'h0);
				boot_done = 1'h1;
				repeat (4) @(negedge ref_clk);
				chk("ready", addr_ready, 16'h1);
				probe(0, {4'h4, 1'h0, k[1:0]});
				chk("port1", {a, hi_port[0]}, 16'h2);
				probe(0, {4'h4, 1'h1, k[1:0]});
				chk("port2", {a, hi_port[0]}, 16'h3);
			end
		end
	endtask
	// Fixed secondary addresses, a near miss, then a full override
	task t_sec;
		begin
			probe(1, 7'h38);
			chk("sec1", {a, hi_port[1]}, 16'h2);
			probe(1, 7'h3F);
			chk("sec2", {a, hi_port[1]}, 16'h3);
			probe(1, 7'h39);
			chk("miss", a, 16'h0);
			addr_ovr_mask = 28'h01FC000;
			addr_ovr_value = 28'h0154000;
			probe(1, 7'h55);
			chk("ovr", {a, hi_port[1]}, 16'h2);
			probe(1, 7'h38);
			chk("ovr_old", a, 16'h0);
			addr_ovr_mask = 28'h0;
		end
	endtask
	// Write with sub-address, then repeated-start read on port two
	task t_xfer;
		begin
			hi_rd_data = 16'h00A5;
			i_dpa_mst.cnd(0, 1'h1);
			i_dpa_mst.wb(8'h4E, a);
			i_dpa_mst.wb(8'h3C, a);
			i_dpa_mst.wb(8'hC3, a);
			chk("wr_ack", a, 16'h1);
			i_dpa_mst.cnd(0, 1'h1);
			i_dpa_mst.wb(8'h4F, a);
			i_dpa_mst.rb(1'h1, b);
			i_dpa_mst.cnd(0, 1'h0);
			chk("sub", hi_subaddr[7:0], 16'h3C);
			chk("wdata", wseen, 16'hC3);
			chk("rdata", b, 16'hA5);
			chk("port", hi_port[0], 16'h1);
			chk("stretch", held, 16'h12);
		end
	endtask
	task t_irq;
		begin
			evt_in = 8'h81;
			irq_mask = 16'h0100;
			repeat (2) @(negedge ref_clk);
			chk("irq_a", irq_out, 16'h2);
			irq_mask = 16'h0080;
			repeat (2) @(negedge ref_clk);
			chk("irq_b", irq_out, 16'h1);
		end
	endtask
	initial begin
		ref_clk = 1'h0;
		nrst = 1'h0;
		boot_done = 1'h0;
		strap_adc_valid = 1'h1;
		strap_adc_code = 10'h0;
		addr_ovr_mask = 28'h0;
		addr_ovr_value = 28'h0;
		hi_rd_data = 16'h0;
		evt_in = 8'h0;
		irq_mask = 16'h0;
		t_strap;
		t_sec;
		t_xfer;
		t_irq;
		print_verdict;
	end
endmodule // dpa_i2c_addr_bench

// [test/dpa_i2c_addr_sva.sv]
// Port-level assertions for the slave address block
`timescale 1ns/1ps
module dpa_i2c_addr_chk #(
	parameter EVT_W = 8
) (
	input wire ref_clk,
	input wire nrst,
	input wire boot_done,
	input wire [1:0] scl_in,
	input wire [1:0] scl_out,
	input wire [1:0] scl_oe,
	input wire [1:0] sda_out,
	input wire [1:0] sda_oe,
	input wire [1:0] hi_wr_stb,
	input wire [1:0] hi_rd_stb,
	input wire [1:0] hi_rdy,
	input wire [EVT_W-1:0] evt_in,
	input wire [2*EVT_W-1:0] irq_mask,
	input wire [1:0] irq_out,
	input wire addr_ready
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);
	// Write strobe comes with the clock hold and is gone a cycle later
	sequence wr_hold;
		hi_wr_stb[0] && scl_oe[0];
	endsequence
	sequence wr_gone;
		##1 !hi_wr_stb[0];
	endsequence
	no_early_ack_a: assert property (
		!addr_ready |-> (sda_oe | scl_oe) == 2'h0)
		else $error("bus driven before addresses set");
	ready_cause_a: assert property (
		$rose(addr_ready) |-> $past(boot_done))
		else $error("ready without boot");
	irq_map_a: assert property (
		$past(nrst) |-> irq_out ==
		{|$past(evt_in & irq_mask[2*EVT_W-1:EVT_W]),
		|$past(evt_in & irq_mask[EVT_W-1:0])})
		else $error("interrupt not masked events");
	wr_pulse_a: assert property (wr_hold |-> wr_gone)
		else $error("write strobe too long");
	stretch_end_a: assert property (
		scl_oe[0] && hi_rdy[0] |=> !scl_oe[0])
		else $error("clock held after ready");
	rd_stall_a: assert property (
		hi_rd_stb[0] |-> scl_oe[0] && !sda_oe[0])
		else $error("read request without hold");
	sda_steady_a: assert property (
		((sda_oe ^ $past(sda_oe)) & $past(scl_in)) == 2'h0)
		else $error("data moved while clock high");
	open_drain_a: assert property (
		(scl_out | sda_out) == 2'h0)
		else $error("line driven high");
endmodule // dpa_i2c_addr_chk

bind dpa_i2c_addr dpa_i2c_addr_chk #(.EVT_W(EVT_W)) i_chk (.ref_clk, .nrst,
	.boot_done, .scl_in, .scl_out, .scl_oe, .sda_out, .sda_oe, .hi_wr_stb,
	.hi_rd_stb, .hi_rdy, .evt_in, .irq_mask, .irq_out, .addr_ready);

// [test/dpa_mst.sv]
// Behavioural bus master for the two slave interfaces
`timescale 1ns/1ps
module dpa_mst (
	input wire ref_clk,
	input wire [1:0] scl,
	input wire [1:0] sda,
	output reg [1:0] scl_low,
	output reg [1:0] sda_low
);
	integer ifc = 0;
	integer n;
	initial begin
		scl_low = 2'h0;
		sda_low = 2'h0;
	end
	// Let the clock go; a stretching slave may keep it low a while
	task ch;
		begin
			scl_low[ifc] = 1'h0;
			for (n = 0; n < 300 && scl[ifc] !== 1'h1; n = n + 1)
				@(negedge ref_clk);
			repeat (4) @(negedge ref_clk);
		end
	endtask
	// One bit: data set a cycle after the fall, sampled late in high
	task bx(input d, output s);
		begin
			@(negedge ref_clk);
			sda_low[ifc] = ~d;
			repeat (3) @(negedge ref_clk);
			ch;
			s = sda[ifc];
			scl_low[ifc] = 1'h1;
		end
	endtask
	// Start when p is set, stop otherwise
	task cnd(input integer i, input p);
		begin
			ifc = i;
			@(negedge ref_clk);
			sda_low[ifc] = ~p;
			repeat (3) @(negedge ref_clk);
			ch;
			sda_low[ifc] = p;
			repeat (4) @(negedge ref_clk);
			scl_low[ifc] = p;
		end
	endtask
	// Byte out MSB first; ack is 1 when the slave pulled data low
	task wb(input [7:0] d, output ack);
		integer k;
		reg s;
		begin
			for (k = 7; k >= 0; k = k - 1)
				bx(d[k], s);
			bx(1'h1, s);
			ack = ~s;
		end
	endtask
	// Byte in MSB first, then ack, or no ack when last is set
	task rb(input last, output [7:0] d);
		integer k;
		reg s;
		begin
			for (k = 7; k >= 0; k = k - 1) begin
				bx(1'h1, s);
				d[k] = s;
			end
			bx(last, s);
		end
	endtask
endmodule // dpa_mst
